// ### src/io_module_failsafe_sync_control.sv
// failsafe, power-on and local bus synchronization control of an i/o module
// assumes an ahb-lite master on the register bus and a station head that
// pulses pd_valid with pd_data and cycle_start, all synchronous to sys_clk
`timescale 1ns/1ps
module io_module_failsafe_sync_control
    import iofs_pkg::*;
#(
    parameter logic [31:0] WDOG_CYCLES = 32'((`WDOG_TIME_US * 1000) / `CLK_PERIOD_NS)
)
(
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        pd_valid,
    input  wire logic [31:0] pd_data,
    input  wire logic        cycle_start,
    input  wire logic [31:0] in_pins,
    output logic      [31:0] out_data,
    output logic      [31:0] in_data,
    output logic             in_valid,
    output logic             failsafe_active,
    output logic             irq
);
    // ====================
    // functions
    function automatic logic [7:0] word_off(input logic [31:0] a);
        word_off = {a[7:2], 2'b00};
    endfunction

    function automatic logic [31:0] fs_value(input fs_code_t    code,
                                             input logic [31:0] last,
                                             input logic [31:0] subst);
        case (code)
            `FS_ZERO:  fs_value = `ZERO_VALUE;
            `FS_FINAL: fs_value = `FINAL_VALUE;
            `FS_HOLD:  fs_value = last;
            `FS_SUBST: fs_value = subst;
            default:   fs_value = `ZERO_VALUE;
        endcase
    endfunction

    // ====================
    // declarations
    localparam logic [31:0] CAPS_WORD = `CAPS_VALUE;
    logic [7:0]       addr_reg;
    logic [7:0]       addr_next;
    logic             wr_pend_reg;
    logic             wr_pend_next;
    logic             rd_wait_reg;
    logic             rd_wait_next;
    logic [31:0]      hrdata_reg;
    logic [31:0]      hrdata_next;
    logic [31:0]      rdata_mux;
    logic             wr_en;

    logic [31:0]      ctrl_reg;
    logic [31:0]      ctrl_next;
    fs_code_t         fs_code_reg;
    fs_code_t         fs_code_next;
    logic [31:0]      subst_reg;
    logic [31:0]      subst_next;
    logic [31:0]      sync_point_reg;
    logic [31:0]      sync_point_next;
    logic [31:0]      wdog_reg;
    logic [31:0]      wdog_next;
    logic [`IRQ_W-1:0] irq_mask_reg;
    logic [`IRQ_W-1:0] irq_mask_next;
    logic [`IRQ_W-1:0] irq_status_reg;
    logic [`IRQ_W-1:0] irq_status_next;
    logic [`IRQ_W-1:0] irq_events;

    run_state_e       state_reg;
    run_state_e       state_next;
    logic [31:0]      out_reg;
    logic [31:0]      out_next;
    logic [31:0]      pd_hold_reg;
    logic [31:0]      pd_hold_next;
    logic             pending_reg;
    logic             pending_next;
    logic [31:0]      in_snap_reg;
    logic [31:0]      in_snap_next;
    logic             in_valid_reg;
    logic             in_valid_next;

    logic             sync_active;
    logic             sync_fire;
    logic             wd_expired;
    logic             snap_now;
    logic [31:0]      proc_time;
    logic [31:0]      status_word;

    // ====================
    // sub-blocks
    assign sync_active = CAPS_WORD[`CAPS_OUT_SYNC] && !ctrl_reg[`CTRL_SYNC_DIS];

    sync_point_timer u_sync_timer (
        .sys_clk     (sys_clk),
        .rstn        (rstn),
        .enable      (sync_active),
        .cycle_start (cycle_start),
        .sync_point  (sync_point_reg),
        .fire        (sync_fire)
    );

    failsafe_watchdog u_watchdog (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .enable  (state_reg == ST_RUN),
        .kick    (pd_valid),
        .period  (wdog_reg),
        .expired (wd_expired)
    );

    // ====================
    // ahb-lite slave: zero-wait writes, one wait state on reads
    assign hreadyout = !rd_wait_reg;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_reg;
    assign wr_en     = wr_pend_reg;

    always_comb begin
        addr_next    = addr_reg;
        wr_pend_next = 1'b0;
        rd_wait_next = 1'b0;
        hrdata_next  = hrdata_reg;
        if (rd_wait_reg) begin
            hrdata_next = rdata_mux;
        end
        if (hsel && htrans[1] && hready) begin
            addr_next    = word_off(haddr);
            wr_pend_next = hwrite;
            rd_wait_next = !hwrite;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            addr_reg    <= 8'h00;
            wr_pend_reg <= 1'b0;
            rd_wait_reg <= 1'b0;
            hrdata_reg  <= 32'h00000000;
        end else begin
            addr_reg    <= addr_next;
            wr_pend_reg <= wr_pend_next;
            rd_wait_reg <= rd_wait_next;
            hrdata_reg  <= hrdata_next;
        end
    end

    // processing time grows when the substitute word must be fetched
    assign proc_time = (fs_code_reg == `FS_SUBST) ? (`PROC_BASE_NS + `PROC_SUBST_NS)
                                                  : `PROC_BASE_NS;

    assign status_word = {28'h0000000, pending_reg, sync_active,
                          (state_reg == ST_FAILSAFE), (state_reg != ST_POWER_ON)};

    always_comb begin
        case (addr_reg)
            `OFF_CTRL:       rdata_mux = ctrl_reg;
            `OFF_FS_CODE:    rdata_mux = {16'h0000, fs_code_reg};
            `OFF_SUBST:      rdata_mux = subst_reg;
            `OFF_CAPS:       rdata_mux = `CAPS_VALUE;
            `OFF_MIN_REPEAT: rdata_mux = `MIN_REPEAT_NS;
            `OFF_PROC_TIME:  rdata_mux = proc_time;
            `OFF_RUNUP:      rdata_mux = `RUNUP_NS;
            `OFF_SYNC_POINT: rdata_mux = sync_point_reg;
            `OFF_STATUS:     rdata_mux = status_word;
            `OFF_IRQ_STATUS: rdata_mux = {28'h0000000, irq_status_reg};
            `OFF_IRQ_MASK:   rdata_mux = {28'h0000000, irq_mask_reg};
            `OFF_WDOG:       rdata_mux = wdog_reg;
            `OFF_OUT_DATA:   rdata_mux = out_reg;
            `OFF_IN_DATA:    rdata_mux = in_snap_reg;
            default:         rdata_mux = 32'h00000000;
        endcase
    end

    // ====================
    // configuration registers
    always_comb begin
        ctrl_next       = ctrl_reg;
        fs_code_next    = fs_code_reg;
        subst_next      = subst_reg;
        sync_point_next = sync_point_reg;
        wdog_next       = wdog_reg;
        irq_mask_next   = irq_mask_reg;
        if (wr_en) begin
            case (addr_reg)
                `OFF_CTRL:       ctrl_next       = {31'h00000000, hwdata[`CTRL_SYNC_DIS]};
                `OFF_FS_CODE:    fs_code_next    = hwdata[15:0];
                `OFF_SUBST:      subst_next      = hwdata;
                `OFF_SYNC_POINT: sync_point_next = hwdata;
                `OFF_WDOG:       wdog_next       = hwdata;
                `OFF_IRQ_MASK:   irq_mask_next   = hwdata[`IRQ_W-1:0];
                default:         ctrl_next       = ctrl_reg;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            ctrl_reg       <= `CTRL_RESET;
            fs_code_reg    <= `FS_ZERO;
            subst_reg      <= `ZERO_VALUE;
            sync_point_reg <= 32'h00000000;
            wdog_reg       <= WDOG_CYCLES;
            irq_mask_reg   <= 4'h0;
        end else begin
            ctrl_reg       <= ctrl_next;
            fs_code_reg    <= fs_code_next;
            subst_reg      <= subst_next;
            sync_point_reg <= sync_point_next;
            wdog_reg       <= wdog_next;
            irq_mask_reg   <= irq_mask_next;
        end
    end

    // ====================
    // interrupt status, write one to clear, new events win
    always_comb begin
        irq_status_next = irq_status_reg;
        if (wr_en && (addr_reg == `OFF_IRQ_STATUS)) begin
            irq_status_next = irq_status_reg & ~hwdata[`IRQ_W-1:0];
        end
        irq_status_next = irq_status_next | irq_events;
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            irq_status_reg <= 4'h0;
        end else begin
            irq_status_reg <= irq_status_next;
        end
    end

    assign irq = |(irq_status_reg & irq_mask_reg);

    // ====================
    // output state machine and input snapshot
    assign snap_now = sync_active ? sync_fire : pd_valid;

    always_comb begin
        state_next    = state_reg;
        out_next      = out_reg;
        pd_hold_next  = pd_hold_reg;
        pending_next  = pending_reg;
        irq_events    = 4'h0;
        in_snap_next  = in_snap_reg;
        in_valid_next = snap_now;
        if (snap_now) begin
            in_snap_next = in_pins;
        end
        if (sync_fire && pending_reg) begin
            pending_next = 1'b0;
        end
        if (pd_valid && sync_active) begin
            if (pending_reg && !sync_fire) begin
                irq_events[`IRQ_OVERRUN] = 1'b1;
            end
            pd_hold_next = pd_data;
            pending_next = 1'b1;
        end
        case (state_reg)
            ST_POWER_ON: begin
                out_next = `POWERON_VALUE;
                if (pd_valid) begin
                    state_next = ST_RUN;
                    irq_events[`IRQ_ARMED] = 1'b1;
                    if (!sync_active) begin
                        out_next = pd_data;
                    end
                end
            end
            ST_RUN: begin
                if (wd_expired) begin
                    state_next = ST_FAILSAFE;
                    irq_events[`IRQ_FAILSAFE] = 1'b1;
                    out_next = fs_value(fs_code_reg, out_reg, subst_reg);
                end else if (!sync_active && pd_valid) begin
                    out_next = pd_data;
                end else if (sync_active && sync_fire && pending_reg) begin
                    out_next = pd_hold_reg;
                end
            end
            ST_FAILSAFE: begin
                out_next = fs_value(fs_code_reg, out_reg, subst_reg);
                if (pd_valid) begin
                    state_next = ST_RUN;
                    irq_events[`IRQ_RECOVER] = 1'b1;
                    if (!sync_active) begin
                        out_next = pd_data;
                    end
                end
            end
            default: begin
                state_next = ST_POWER_ON;
                out_next   = `POWERON_VALUE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            state_reg    <= ST_POWER_ON;
            out_reg      <= `POWERON_VALUE;
            pd_hold_reg  <= 32'h00000000;
            pending_reg  <= 1'b0;
            in_snap_reg  <= 32'h00000000;
            in_valid_reg <= 1'b0;
        end else begin
            state_reg    <= state_next;
            out_reg      <= out_next;
            pd_hold_reg  <= pd_hold_next;
            pending_reg  <= pending_next;
            in_snap_reg  <= in_snap_next;
            in_valid_reg <= in_valid_next;
        end
    end

    assign out_data        = out_reg;
    assign in_data         = in_snap_reg;
    assign in_valid        = in_valid_reg;
    assign failsafe_active = (state_reg == ST_FAILSAFE);
endmodule

// ### src/iofs_regs.svh
// register map, field positions, codes, reset values and timing figures
// assumes inclusion by bare name from the package and the bench modules
//
// Overview of operation
// - outputs keep the power-on value until the first valid process data arrives
// - failsafe reaction is armed only after the first valid process data exchange
// - armed module switches outputs to configured failsafe when process data stops
// - failsafe code 0000 drives zeros, code 0001 drives full-scale final values
// - code 0002 holds last output, code 0003 drives the substitute output word
// - capabilities register advertises input and output synchronization flags
// - all signals of the module are sampled or driven at one common instant
// - minimum repeat, processing duration and run-up times are reported to the head
// - unsynchronized module transfers values as fast as possible, no schedule
// - a control bit disables synchronous mode, the module then runs asynchronously
`ifndef IOFS_REGS_SVH
`define IOFS_REGS_SVH

// ====================
// register byte offsets
`define OFF_CTRL        8'h00
`define OFF_FS_CODE     8'h04
`define OFF_SUBST       8'h08
`define OFF_CAPS        8'h0c
`define OFF_MIN_REPEAT  8'h10
`define OFF_PROC_TIME   8'h14
`define OFF_RUNUP       8'h18
`define OFF_SYNC_POINT  8'h1c
`define OFF_STATUS      8'h20
`define OFF_IRQ_STATUS  8'h24
`define OFF_IRQ_MASK    8'h28
`define OFF_WDOG        8'h2c
`define OFF_OUT_DATA    8'h30
`define OFF_IN_DATA     8'h34

// ====================
// fields
`define CTRL_SYNC_DIS   0
`define CAPS_IN_SYNC    0
`define CAPS_OUT_SYNC   1
`define IRQ_ARMED       0
`define IRQ_FAILSAFE    1
`define IRQ_RECOVER     2
`define IRQ_OVERRUN     3
`define IRQ_W           4

// ====================
// codes and values
`define FS_ZERO         16'h0000
`define FS_FINAL        16'h0001
`define FS_HOLD         16'h0002
`define FS_SUBST        16'h0003
`define ZERO_VALUE      32'h00000000
`define FINAL_VALUE     32'hffffffff
`define POWERON_VALUE   32'h00000000
`define CAPS_VALUE      32'h00000003
`define CTRL_RESET      32'h00000000

// ====================
// timing, reported values in ns
`define CLK_PERIOD_NS   8
`define WDOG_TIME_US    1000
`define MIN_REPEAT_NS   32'h00002710
`define PROC_BASE_NS    32'h000007d0
`define PROC_SUBST_NS   32'h000001f4
`define RUNUP_NS        32'h000003e8

`endif

// ### src/iofs_pkg.sv
// types shared by the failsafe and synchronization control
// assumes the register header is on the include path
package iofs_pkg;
    `include "iofs_regs.svh"

    typedef enum logic [1:0] {
        ST_POWER_ON,
        ST_RUN,
        ST_FAILSAFE
    } run_state_e;

    typedef logic [15:0] fs_code_t;
endpackage

// ### src/sync_point_timer.sv
// counts from each cycle start and fires once at the programmed time point
// assumes cycle_start is a one-cycle pulse from the station head
`timescale 1ns/1ps
module sync_point_timer
    import iofs_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    input  wire logic        enable,
    input  wire logic        cycle_start,
    input  wire logic [31:0] sync_point,
    output logic             fire
);
    logic [31:0] count_reg;
    logic [31:0] count_next;
    logic        armed_reg;
    logic        armed_next;

    assign fire = armed_reg && (count_reg == sync_point);

    always_comb begin
        count_next = count_reg;
        armed_next = armed_reg;
        if (!enable) begin
            armed_next = 1'b0;
        end else if (cycle_start) begin
            count_next = 32'h00000000;
            armed_next = 1'b1;
        end else begin
            if (fire) begin
                armed_next = 1'b0;
            end
            if (count_reg != 32'hffffffff) begin
                count_next = count_reg + 32'h00000001;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            count_reg <= 32'h00000000;
            armed_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            armed_reg <= armed_next;
        end
    end
endmodule

// ### src/failsafe_watchdog.sv
// pulses once when no kick has come for the programmed number of cycles
// assumes kick is a one-cycle pulse per valid process data cycle
`timescale 1ns/1ps
module failsafe_watchdog
    import iofs_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    input  wire logic        enable,
    input  wire logic        kick,
    input  wire logic [31:0] period,
    output logic             expired
);
    logic [31:0] count_reg;
    logic [31:0] count_next;
    logic        done_reg;
    logic        done_next;

    assign expired = enable && !kick && !done_reg && (period != 32'h00000000)
                     && (count_reg >= period);

    always_comb begin
        count_next = count_reg;
        done_next  = done_reg;
        if (!enable || kick) begin
            count_next = 32'h00000000;
            done_next  = 1'b0;
        end else begin
            if (expired) begin
                done_next = 1'b1;
            end
            if (count_reg != 32'hffffffff) begin
                count_next = count_reg + 32'h00000001;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            count_reg <= 32'h00000000;
            done_reg  <= 1'b0;
        end else begin
            count_reg <= count_next;
            done_reg  <= done_next;
        end
    end
endmodule

// ### bench/iofs_monitor.sv
// checker of the failsafe and synchronization control, top ports only
// assumes a bind onto the top module with its watchdog parameter handed on
`timescale 1ns/1ps
`include "iofs_regs.svh"
module iofs_monitor
    import iofs_pkg::*;
#(
    parameter logic [31:0] WDOG_CYCLES = 32'd20
)
(
    input wire logic        sys_clk,
    input wire logic        rstn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        pd_valid,
    input wire logic [31:0] pd_data,
    input wire logic        cycle_start,
    input wire logic [31:0] in_pins,
    input wire logic [31:0] out_data,
    input wire logic [31:0] in_data,
    input wire logic        in_valid,
    input wire logic        failsafe_active,
    input wire logic        irq
);
    // ==========================================================
    // shadow of written control values
    logic        take, rd_caps;
    logic        wp_reg, wp_next, seen_reg, seen_next, asy_reg, asy_next;
    logic [5:0]  wa_reg, wa_next;
    logic [15:0] fs_reg, fs_next;
    logic [31:0] sub_reg, sub_next, wd_reg, wd_next, idle_reg, idle_next;
    assign take    = hsel && htrans[1] && hready;
    assign rd_caps = take && !hwrite && haddr[7:2] == 6'h03;
    always_comb begin
        wp_next   = take && hwrite;
        wa_next   = haddr[7:2];
        seen_next = seen_reg || pd_valid;
        idle_next = pd_valid ? 32'h0 : idle_reg + 32'h1;
        asy_next  = asy_reg;
        fs_next   = fs_reg;
        sub_next  = sub_reg;
        wd_next   = wd_reg;
        if (wp_reg && hready) begin
            case (wa_reg)
                6'h00:   asy_next = hwdata[0];
                6'h01:   fs_next = hwdata[15:0];
                6'h02:   sub_next = hwdata;
                6'h0b:   wd_next = hwdata;
                default: ;
            endcase
        end
    end
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            wp_reg   <= 1'b0;
            wa_reg   <= 6'h0;
            seen_reg <= 1'b0;
            idle_reg <= 32'h0;
            asy_reg  <= 1'b0;
            fs_reg   <= 16'h0;
            sub_reg  <= 32'h0;
            wd_reg   <= WDOG_CYCLES;
        end else begin
            wp_reg   <= wp_next;
            wa_reg   <= wa_next;
            seen_reg <= seen_next;
            idle_reg <= idle_next;
            asy_reg  <= asy_next;
            fs_reg   <= fs_next;
            sub_reg  <= sub_next;
            wd_reg   <= wd_next;
        end
    end
    // ==========================================================
    // properties
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    a_poweron_hold: assert property (
        !seen_reg |-> out_data == `POWERON_VALUE && !failsafe_active)
        else $error("output left power-on value");
    a_arm_first: assert property (
        $rose(failsafe_active) |-> seen_reg) else $error("failsafe before arming");
    a_fs_zero: assert property (
        $rose(failsafe_active) && fs_reg == `FS_ZERO |-> ##[0:1] out_data == `ZERO_VALUE)
        else $error("zero substitute missing");
    a_fs_final: assert property (
        $rose(failsafe_active) && fs_reg == `FS_FINAL |-> ##[0:1] out_data == `FINAL_VALUE)
        else $error("final substitute missing");
    a_fs_hold: assert property (
        $rose(failsafe_active) && fs_reg == `FS_HOLD |-> $stable(out_data) ##1 $stable(out_data))
        else $error("hold substitute changed output");
    a_fs_subst: assert property (
        $rose(failsafe_active) && fs_reg == `FS_SUBST |-> ##[0:1] out_data == sub_reg)
        else $error("substitute word not driven");
    a_fs_timing: assert property (
        $rose(failsafe_active) |-> wd_reg != 32'h0 && idle_reg + 32'd2 >= wd_reg)
        else $error("failsafe entered too early");
    a_async_apply: assert property (
        asy_reg && pd_valid |=> out_data == $past(pd_data) && in_valid)
        else $error("async data not applied at once");
    a_snap_common: assert property (
        in_valid |-> in_data == $past(in_pins)) else $error("input snapshot mismatch");
    a_sync_defer: assert property (
        !asy_reg && pd_valid && cycle_start |=> $stable(out_data))
        else $error("sync data applied before time point");
    a_caps_read: assert property (
        rd_caps |=> !hreadyout ##1 hreadyout && hrdata == `CAPS_VALUE)
        else $error("capabilities read wrong");
    a_resp_okay: assert property (hresp == 1'b0) else $error("error response on bus");
    c_failsafe: cover property ($rose(failsafe_active));
    c_sync_apply: cover property (in_valid && !asy_reg);
    c_irq: cover property ($rose(irq));
endmodule

bind io_module_failsafe_sync_control iofs_monitor #(.WDOG_CYCLES(WDOG_CYCLES)) mon (
    .sys_clk(sys_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pd_valid(pd_valid), .pd_data(pd_data),
    .cycle_start(cycle_start), .in_pins(in_pins), .out_data(out_data),
    .in_data(in_data), .in_valid(in_valid), .failsafe_active(failsafe_active), .irq(irq));

// ### bench/station_head_model.sv
// station head model: process data pulses and the cycle start reference
// assumes calls right after a rising edge of sys_clk
`timescale 1ns/1ps
module station_head_model (
    input  wire logic        sys_clk,
    output logic             pd_valid,
    output logic [31:0]      pd_data,
    output logic             cycle_start
);
    initial begin
        pd_valid    = 1'b0;
        pd_data     = 32'h0;
        cycle_start = 1'b0;
    end
    // one process data cycle, optionally on the sync reference
    task automatic send(input logic [31:0] d, input logic cs);
        pd_valid    <= 1'b1;
        pd_data     <= d;
        cycle_start <= cs;
        @(posedge sys_clk);
        pd_valid    <= 1'b0;
        pd_data     <= ~d;
        cycle_start <= 1'b0;
    endtask
endmodule

// ### bench/io_module_failsafe_sync_control_tb_top.sv
// bench of the failsafe and synchronization control
// assumes the monitor is bound and the station head model drives process data
`timescale 1ns/1ps
`include "iofs_regs.svh"
module io_module_failsafe_sync_control_tb_top
    import iofs_pkg::*;
;
    localparam logic [31:0] WDOG = 32'd20;
    logic        sys_clk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [1:0]  htrans = 2'b00;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, in_pins = 32'h0;
    logic [31:0] hrdata, out_data, in_data, pd_data;
    logic        hready, hreadyout, hresp, in_valid, failsafe_active, irq;
    logic        pd_valid, cycle_start;
    logic [31:0] fsx [4];
    int          fail_count = 0;
    int          n_compared = 0;
    int          c;
    assign hready = hreadyout;
    always #4 sys_clk = ~sys_clk;
    always @(posedge sys_clk) in_pins <= in_pins + 32'h01010101;

    io_module_failsafe_sync_control #(.WDOG_CYCLES(WDOG)) DUT (
        .sys_clk(sys_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pd_valid(pd_valid),
        .pd_data(pd_data), .cycle_start(cycle_start), .in_pins(in_pins),
        .out_data(out_data), .in_data(in_data), .in_valid(in_valid),
        .failsafe_active(failsafe_active), .irq(irq));
    station_head_model head (.sys_clk(sys_clk), .pd_valid(pd_valid), .pd_data(pd_data),
        .cycle_start(cycle_start));

    // ==========================================================
    // tasks
    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wt;
        int i;
        for (i = 0; i < 64; i++) begin
            @(posedge sys_clk);
            if (hready === 1'b1) break;
        end
        if (i == 64) begin
            fail_count++;
            end_sim;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= {24'h0, a};
        hwrite <= 1'b1;
        wt;
        htrans <= 2'b00;
        hwdata <= v;
        wt;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hffffffff);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= {24'h0, a};
        hwrite <= 1'b0;
        wt;
        htrans <= 2'b00;
        wt;
        chk(hrdata & m, e);
    endtask
    // cycles from the process data pulse until the output shows it
    task automatic apply(input logic [31:0] v, input logic cs, input int n_exp);
        int n;
        head.send(v, cs);
        for (n = 1; n < 64; n++) begin
            @(posedge sys_clk);
            if (out_data === v) break;
        end
        chk(32'(n), 32'(n_exp));
    endtask
    task automatic wait_fs;
        int i;
        for (i = 0; i < 200; i++) begin
            @(posedge sys_clk);
            if (failsafe_active === 1'b1) break;
        end
        if (i == 200) begin
            fail_count++;
            end_sim;
        end
        repeat (2) @(posedge sys_clk);
    endtask

    // ==========================================================
    // sequence
    initial begin
        fsx = '{`ZERO_VALUE, `FINAL_VALUE, 32'h12340002, 32'h5a5a5a5a};
        repeat (12) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        rdc(`OFF_CAPS, `CAPS_VALUE);
        wr(`OFF_CAPS, 32'h0);
        rdc(`OFF_CAPS, `CAPS_VALUE);
        rdc(`OFF_MIN_REPEAT, `MIN_REPEAT_NS);
        rdc(`OFF_PROC_TIME, `PROC_BASE_NS);
        rdc(`OFF_RUNUP, `RUNUP_NS);
        rdc(8'h3c, 32'h0);
        rdc(`OFF_WDOG, WDOG);
        rdc(`OFF_IRQ_MASK, 32'h0);
        repeat (3 * WDOG) @(posedge sys_clk);
        chk({31'h0, failsafe_active}, 32'h0);
        chk(out_data, `POWERON_VALUE);
        rdc(`OFF_STATUS, 32'h0, 32'h3);
        wr(`OFF_CTRL, 32'h1);
        wr(`OFF_IRQ_MASK, 32'hf);
        wr(`OFF_SUBST, fsx[3]);
        for (c = 0; c < 4; c++) begin
            wr(`OFF_FS_CODE, 32'(c));
            apply(32'h12340000 + 32'(c), 1'b0, 1);
            rdc(`OFF_STATUS, 32'h1, 32'h3);
            if (c == 3) rdc(`OFF_PROC_TIME, `PROC_BASE_NS + `PROC_SUBST_NS);
            wait_fs;
            chk(out_data, fsx[c]);
            rdc(`OFF_STATUS, 32'h3, 32'h3);
            chk({31'h0, irq}, 32'h1);
            rdc(`OFF_IRQ_STATUS, (c == 0) ? 32'h3 : 32'h6, 32'hf);
            wr(`OFF_IRQ_STATUS, 32'hf);
            @(posedge sys_clk);
            chk({31'h0, irq}, 32'h0);
        end
        wr(`OFF_CTRL, 32'h0);
        wr(`OFF_SYNC_POINT, 32'h3);
        apply(32'h00c0ffee, 1'b1, 5);
        wr(`OFF_SYNC_POINT, 32'h0);
        apply(32'h00beef00, 1'b1, 2);
        end_sim;
    end
endmodule
